// >>> hdl/csdu_top.sv
// Clock select and divide unit with its AXI4-Lite register slave.
// Source clocks are pins, much slower than aclk, synchronised here.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module csdu_top #(
   parameter int RATIO_W = csdu_pkg::CSDU_RATIO_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [csdu_pkg::CSDU_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [csdu_pkg::CSDU_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic lp_osc_clk,
   input wire logic xosc_clk,
   input wire logic pll_aux_clk,
   input wire logic ext_pin_clk,
   input wire logic ref_clk,
   input wire logic diff_in_clk,
   output logic sys_clk,
   output logic aux_clk,
   output logic cpu_clk,
   output logic spi_master_clk,
   output logic main_clk,
   output logic backend_clk,
   output logic xosc_en,
   output logic xosc_bypass,
   output logic xosc_discap,
   output logic xosc_dislvl,
   output logic lp_osc_disable
);
   import csdu_pkg::*;

   // The processor divider needs two to the seventh in its ratio
   if (RATIO_W < 8)
   begin : g_bad_ratio
      $error("csdu_top: RATIO_W too small for divide by 128");
   end

   // Two-flop synchronisers, one per source pin
   logic [CSDU_NUM_SRC-1:0] pins, sync1_r, sync2_r;
   assign pins = {diff_in_clk, ref_clk, ext_pin_clk, pll_aux_clk,
                  xosc_clk, lp_osc_clk};
   for (genvar i = 0; i < CSDU_NUM_SRC; i++)
   begin : g_sync
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            sync1_r[i] <= 1'b0;
            sync2_r[i] <= 1'b0;
         end
         else
         begin
            sync1_r[i] <= pins[i];
            sync2_r[i] <= sync1_r[i];
         end
      end
   end

   // Register file
   csdu_byte_t clk_ctrl_r, clk_ctrl_nxt;
   csdu_byte_t main_ctrl_r, main_ctrl_nxt;
   csdu_byte_t osc_ctrl_r, osc_ctrl_nxt;

   // Write channel: address and data may come in either order
   logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic [7:0] aw_idx_r, aw_idx_nxt;
   csdu_byte_t wdata_r, wdata_nxt;
   logic wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic aw_fire, w_fire, do_write, wr_lane;
   logic [7:0] wr_idx;
   csdu_byte_t wr_data;

   // Read channel
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic ar_fire;
   logic [7:0] rd_idx;
   csdu_byte_t status;

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign aw_fire = s_axi_awvalid && s_axi_awready;
   assign w_fire = s_axi_wvalid && s_axi_wready;
   assign ar_fire = s_axi_arvalid && s_axi_arready;
   assign wr_idx = aw_fire ? s_axi_awaddr[9:2] : aw_idx_r;
   assign wr_data = w_fire ? s_axi_wdata[7:0] : wdata_r;
   assign wr_lane = w_fire ? s_axi_wstrb[0] : wstrb_r;
   assign do_write = (aw_held_r || aw_fire) && (w_held_r || w_fire);
   assign rd_idx = s_axi_araddr[9:2];

   always_comb
   begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      aw_idx_nxt = aw_idx_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      clk_ctrl_nxt = clk_ctrl_r;
      main_ctrl_nxt = main_ctrl_r;
      osc_ctrl_nxt = osc_ctrl_r;
      if (aw_fire)
      begin
         aw_held_nxt = 1'b1;
         aw_idx_nxt = s_axi_awaddr[9:2];
      end
      if (w_fire)
      begin
         w_held_nxt = 1'b1;
         wdata_nxt = s_axi_wdata[7:0];
         wstrb_nxt = s_axi_wstrb[0];
      end
      if (bvalid_r && s_axi_bready)
         bvalid_nxt = 1'b0;
      if (do_write)
      begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = CSDU_RESP_OKAY;
         // Only byte lane 0 carries register bits
         unique case (wr_idx)
            CSDU_IDX_CLK_CTRL:
            begin
               if (wr_lane)
                  clk_ctrl_nxt = wr_data;
            end
            CSDU_IDX_MAIN_CTRL:
            begin
               if (wr_lane)
                  main_ctrl_nxt = wr_data;
            end
            CSDU_IDX_OSC_CTRL:
            begin
               if (wr_lane)
                  osc_ctrl_nxt = wr_data & CSDU_OSC_CTRL_MASK;
            end
            CSDU_IDX_STATUS: ;
            default: bresp_nxt = CSDU_RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_idx_r <= 8'h00;
         wdata_r <= 8'h00;
         wstrb_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= CSDU_RESP_OKAY;
         clk_ctrl_r <= CSDU_CLK_CTRL_RST;
         main_ctrl_r <= CSDU_MAIN_CTRL_RST;
         osc_ctrl_r <= CSDU_OSC_CTRL_RST;
      end
      else
      begin
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         aw_idx_r <= aw_idx_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         clk_ctrl_r <= clk_ctrl_nxt;
         main_ctrl_r <= main_ctrl_nxt;
         osc_ctrl_r <= osc_ctrl_nxt;
      end
   end

   always_comb
   begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && s_axi_rready)
         rvalid_nxt = 1'b0;
      if (ar_fire)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = CSDU_RESP_OKAY;
         rdata_nxt = 32'h0000_0000;
         unique case (rd_idx)
            CSDU_IDX_CLK_CTRL: rdata_nxt[7:0] = clk_ctrl_r;
            CSDU_IDX_STATUS: rdata_nxt[7:0] = status;
            CSDU_IDX_MAIN_CTRL: rdata_nxt[7:0] = main_ctrl_r;
            CSDU_IDX_OSC_CTRL: rdata_nxt[7:0] = osc_ctrl_r;
            default: rresp_nxt = CSDU_RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= CSDU_RESP_OKAY;
      end
      else
      begin
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Oscillator controls come straight from register bits
   assign xosc_en = osc_ctrl_r[CSDU_XEN_BIT];
   assign xosc_bypass = osc_ctrl_r[CSDU_BYPASS_BIT];
   assign xosc_discap = osc_ctrl_r[CSDU_DISCAP_BIT];
   assign lp_osc_disable = osc_ctrl_r[CSDU_LPDIS_BIT];
   assign xosc_dislvl = osc_ctrl_r[CSDU_DISLVL_BIT];

   // Clock tree: every selector hands over glitch-free
   logic sys_cur, aux_cur, cpu_cur, spi_cur;
   logic [1:0] main_cur, main_req;
   logic cpu_src, spi_src, pre_clk;
   logic spi_run, pre_run, bk_run;
   logic [2:0] spi_code, pre_code, cpu_field, bdiv_code;
   logic [RATIO_W-1:0] cpu_ratio, spi_ratio, pre_ratio, bk_ratio;

   csdu_clk_sel #(.N(2), .SEL_W(1), .RST_SEL(1'b0)) u_sys_sel (
      .aclk(aclk), .aresetn(aresetn),
      .clk_in(sync2_r[CSDU_SRC_XOSC:CSDU_SRC_LP]),
      .sel_req(osc_ctrl_r[CSDU_SYS_SEL_BIT]),
      .cur_sel(sys_cur), .clk_o(sys_clk));
   // Starts on the PLL side and moves to the pin once both inputs and the output are low
   csdu_clk_sel #(.N(2), .SEL_W(1), .RST_SEL(1'b0)) u_aux_sel (
      .aclk(aclk), .aresetn(aresetn),
      .clk_in(sync2_r[CSDU_SRC_EXT:CSDU_SRC_PLLAUX]),
      .sel_req(osc_ctrl_r[CSDU_AUX_SEL_BIT]),
      .cur_sel(aux_cur), .clk_o(aux_clk));
   csdu_clk_sel #(.N(2), .SEL_W(1), .RST_SEL(1'b0)) u_cpu_sel (
      .aclk(aclk), .aresetn(aresetn), .clk_in({aux_clk, sys_clk}),
      .sel_req(clk_ctrl_r[CSDU_CPU_SEL_BIT]),
      .cur_sel(cpu_cur), .clk_o(cpu_src));
   csdu_clk_sel #(.N(2), .SEL_W(1), .RST_SEL(1'b0)) u_spi_sel (
      .aclk(aclk), .aresetn(aresetn), .clk_in({aux_clk, sys_clk}),
      .sel_req(clk_ctrl_r[CSDU_SPI_SEL_BIT]),
      .cur_sel(spi_cur), .clk_o(spi_src));
   // Upper select bit alone picks the differential input
   assign main_req = main_ctrl_r[CSDU_MCLK_SEL_LSB+1] ? 2'h2 :
                     {1'b0, main_ctrl_r[CSDU_MCLK_SEL_LSB]};
   csdu_clk_sel #(.N(3), .SEL_W(2), .RST_SEL(2'h0)) u_main_sel (
      .aclk(aclk), .aresetn(aresetn),
      .clk_in({sync2_r[CSDU_SRC_DIFF], aux_clk, sys_clk}),
      .sel_req(main_req), .cur_sel(main_cur), .clk_o(main_clk));

   assign spi_code = clk_ctrl_r[CSDU_SPI_DIV_LSB +: 3];
   assign cpu_field = clk_ctrl_r[CSDU_CPU_DIV_LSB +: 3];
   assign pre_code = main_ctrl_r[CSDU_PRE_LSB +: 3];
   assign bdiv_code = main_ctrl_r[CSDU_BDIV_LSB +: 3];
   assign cpu_ratio = RATIO_W'(1) << cpu_field;
   assign spi_ratio = (spi_code == 3'h0) ? '0 :
                      RATIO_W'(1) << (spi_code - 3'h1);
   assign pre_ratio = (pre_code == 3'h0) ? '0 :
                      RATIO_W'(1) << (pre_code - 3'h1);
   assign bk_ratio = RATIO_W'(bdiv_code) + RATIO_W'(1);

   csdu_clk_div #(.RATIO_W(RATIO_W)) u_cpu_div (
      .aclk(aclk), .aresetn(aresetn), .src(cpu_src),
      .ratio_req(cpu_ratio), .run_o(), .clk_o(cpu_clk));
   csdu_clk_div #(.RATIO_W(RATIO_W)) u_spi_div (
      .aclk(aclk), .aresetn(aresetn), .src(spi_src),
      .ratio_req(spi_ratio), .run_o(spi_run), .clk_o(spi_master_clk));
   csdu_clk_div #(.RATIO_W(RATIO_W)) u_pre_div (
      .aclk(aclk), .aresetn(aresetn), .src(sync2_r[CSDU_SRC_REF]),
      .ratio_req(pre_ratio), .run_o(pre_run), .clk_o(pre_clk));
   csdu_clk_div #(.RATIO_W(RATIO_W)) u_bk_div (
      .aclk(aclk), .aresetn(aresetn), .src(pre_clk),
      .ratio_req(bk_ratio), .run_o(bk_run), .clk_o(backend_clk));

   // Status shows the system, auxiliary, serial and main selections in force and which of the serial, prescaler and backend dividers run
   assign status = {bk_run, pre_run, spi_run, main_cur, spi_cur,
                    aux_cur ^ cpu_cur ^ cpu_cur, sys_cur};

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_spi_stops: assert property ((spi_code == 3'h0 && !spi_run)
      |-> !spi_master_clk)
      else $error("serial clock runs while stopped");
   a_spi_source: assert property ($changed(spi_cur)
      |-> spi_cur == clk_ctrl_r[CSDU_SPI_SEL_BIT])
      else $error("serial source moved away from request");
   a_cpu_pow2: assert property ($onehot(cpu_ratio)
      && cpu_ratio[cpu_field])
      else $error("processor ratio not two to the field");
   a_cpu_source: assert property ($changed(cpu_cur)
      |-> cpu_cur == clk_ctrl_r[CSDU_CPU_SEL_BIT])
      else $error("processor source moved away from request");
   a_main_source: assert property ($changed(main_cur) |->
      main_cur == (main_ctrl_r[7] ? 2'h2 : {1'b0, main_ctrl_r[6]}))
      else $error("main clock source wrong");
   a_pre_stops: assert property ((pre_code == 3'h0 && !pre_run)
      |-> !pre_clk)
      else $error("prescaler runs while disabled");
   a_bk_range: assert property (bk_ratio >= RATIO_W'(1)
      && bk_ratio <= RATIO_W'(8) && bk_ratio - 1'b1 == bdiv_code)
      else $error("backend ratio out of range");
   a_aux_write: assert property (do_write && wr_lane
      && wr_idx == CSDU_IDX_OSC_CTRL |=> $past(wr_data[6]) == osc_ctrl_r[6])
      else $error("auxiliary select not written");
   a_sys_write: assert property (do_write && wr_lane
      && wr_idx == CSDU_IDX_OSC_CTRL |=> $past(wr_data[5]) == osc_ctrl_r[5])
      else $error("system select not written");
   a_osc_write: assert property (do_write && wr_lane
      && wr_idx == CSDU_IDX_OSC_CTRL |=> {xosc_bypass, xosc_discap, xosc_en,
      lp_osc_disable} == {$past(wr_data[4]), $past(wr_data[2]),
      $past(wr_data[1]), $past(wr_data[0])})
      else $error("oscillator control outputs wrong");
   a_lvl_write: assert property (do_write && wr_lane
      && wr_idx == CSDU_IDX_OSC_CTRL |=> xosc_dislvl == $past(wr_data[3]))
      else $error("level shifter disable wrong");
   c_write_osc: cover property (do_write && wr_idx == CSDU_IDX_OSC_CTRL);
   c_spi_runs: cover property (spi_run ##[1:200] $rose(spi_master_clk));
   c_main_diff: cover property ($changed(main_cur) && main_cur == 2'h2);
   c_bk_runs: cover property (bk_run ##[1:500] $rose(backend_clk));
endmodule // csdu_top

// >>> include/csdu_pkg.sv
// Constants, field layout and types of the clock select and divide unit.
// Assumes a single bus clock domain; source clocks arrive as slow levels.
package csdu_pkg;
   localparam int CSDU_ADDR_W = 10;
   localparam int CSDU_RATIO_W = 8;
   // Register indices; the byte address is four times the index
   localparam logic [7:0] CSDU_IDX_CLK_CTRL = 8'h47;
   localparam logic [7:0] CSDU_IDX_STATUS = 8'h48;
   localparam logic [7:0] CSDU_IDX_MAIN_CTRL = 8'h49;
   localparam logic [7:0] CSDU_IDX_OSC_CTRL = 8'h4a;
   localparam logic [7:0] CSDU_CLK_CTRL_RST = 8'h00;
   localparam logic [7:0] CSDU_MAIN_CTRL_RST = 8'h00;
   localparam logic [7:0] CSDU_OSC_CTRL_RST = 8'h48;
   localparam logic [7:0] CSDU_OSC_CTRL_MASK = 8'h7f;
   // Processor and serial clock control fields
   localparam int CSDU_SPI_DIV_LSB = 5;
   localparam int CSDU_SPI_SEL_BIT = 4;
   localparam int CSDU_CPU_DIV_LSB = 1;
   localparam int CSDU_CPU_SEL_BIT = 0;
   // Main and backend clock control fields
   localparam int CSDU_MCLK_SEL_LSB = 6;
   localparam int CSDU_PRE_LSB = 3;
   localparam int CSDU_BDIV_LSB = 0;
   // Oscillator source control fields
   localparam int CSDU_AUX_SEL_BIT = 6;
   localparam int CSDU_SYS_SEL_BIT = 5;
   localparam int CSDU_BYPASS_BIT = 4;
   localparam int CSDU_DISLVL_BIT = 3;
   localparam int CSDU_DISCAP_BIT = 2;
   localparam int CSDU_XEN_BIT = 1;
   localparam int CSDU_LPDIS_BIT = 0;
   // Synchronised source pins, one bit each
   localparam int CSDU_NUM_SRC = 6;
   typedef enum logic [2:0] {
      CSDU_SRC_LP = 3'h0,
      CSDU_SRC_XOSC = 3'h1,
      CSDU_SRC_PLLAUX = 3'h2,
      CSDU_SRC_EXT = 3'h3,
      CSDU_SRC_REF = 3'h4,
      CSDU_SRC_DIFF = 3'h5
   } csdu_src_t;
   typedef logic [7:0] csdu_byte_t;
   localparam logic [1:0] CSDU_RESP_OKAY = 2'h0;
   localparam logic [1:0] CSDU_RESP_SLVERR = 2'h2;
endpackage

// >>> hdl/csdu_clk_sel.sv
// Glitch-free selector of one clock level among several.
// Inputs are levels already synchronised to aclk.
`timescale 1ns/100ps
module csdu_clk_sel #(
   parameter int N = 2,
   parameter int SEL_W = 1,
   parameter logic [SEL_W-1:0] RST_SEL = '0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [N-1:0] clk_in,
   input wire logic [SEL_W-1:0] sel_req,
   output logic [SEL_W-1:0] cur_sel,
   output logic clk_o
);
   import csdu_pkg::*;
   logic [SEL_W-1:0] cur_sel_r, cur_sel_nxt;
   logic clk_r, clk_nxt;

   if (N < 2 || N > (1 << SEL_W))
   begin : g_bad_n
      $error("csdu_clk_sel: N does not fit SEL_W");
   end

   // Hand over only while the output and both clocks are low; checking
   // the output too keeps the low phase at two cycles even when the new
   // clock rises right after the switch
   always_comb
   begin
      cur_sel_nxt = cur_sel_r;
      if (sel_req != cur_sel_r && int'(sel_req) < N && !clk_r &&
          !clk_in[cur_sel_r] && !clk_in[sel_req])
         cur_sel_nxt = sel_req;
      clk_nxt = clk_in[cur_sel_nxt];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cur_sel_r <= RST_SEL;
         clk_r <= 1'b0;
      end
      else
      begin
         cur_sel_r <= cur_sel_nxt;
         clk_r <= clk_nxt;
      end
   end

   assign cur_sel = cur_sel_r;
   assign clk_o = clk_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_sel_switch_low: assert property ($changed(cur_sel_r)
      |-> !clk_r && !$past(clk_r))
      else $error("selector switched around a high output");
endmodule // csdu_clk_sel

// >>> hdl/csdu_clk_div.sv
// Integer clock divider counting both edges of a source level.
// Source must change no faster than every second aclk cycle.
`timescale 1ns/100ps
module csdu_clk_div #(
   parameter int RATIO_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic src,
   input wire logic [RATIO_W-1:0] ratio_req,
   output logic run_o,
   output logic clk_o
);
   import csdu_pkg::*;
   logic src_r, src_nxt;
   logic out_r, out_nxt;
   logic [RATIO_W-1:0] cnt_r, cnt_nxt;
   logic [RATIO_W-1:0] ratio_r, ratio_nxt;
   logic edge_seen;

   if (RATIO_W < 1)
   begin : g_bad_ratio
      $error("csdu_clk_div: RATIO_W must be positive");
   end

   // Ratio 0 holds the output low; output toggles every ratio edges
   always_comb
   begin
      src_nxt = src;
      edge_seen = src != src_r;
      out_nxt = out_r;
      cnt_nxt = cnt_r;
      ratio_nxt = ratio_r;
      // New ratio only at a period boundary, never mid half-period
      if (!out_r && cnt_r == '0)
         ratio_nxt = ratio_req;
      if (ratio_r == '0)
      begin
         out_nxt = 1'b0;
         cnt_nxt = '0;
      end
      else if (edge_seen)
      begin
         if (cnt_r == ratio_r - 1'b1)
         begin
            out_nxt = !out_r;
            cnt_nxt = '0;
         end
         else
            cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         src_r <= 1'b0;
         out_r <= 1'b0;
         cnt_r <= '0;
         ratio_r <= '0;
      end
      else
      begin
         src_r <= src_nxt;
         out_r <= out_nxt;
         cnt_r <= cnt_nxt;
         ratio_r <= ratio_nxt;
      end
   end

   assign run_o = ratio_r != '0;
   assign clk_o = out_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_div_toggle_cnt: assert property ($changed(out_r) |->
      $past(edge_seen) && $past(cnt_r) == $past(ratio_r) - 1'b1)
      else $error("divider toggled before the full count");
   a_div_stop_low: assert property (ratio_r == '0 |=> !out_r)
      else $error("stopped divider output not low");
endmodule // csdu_clk_div

// >>> tb/csdu_top_tb_top.sv
// Self-checking bench of the clock select and divide unit.
// Assumes the bench drives every source clock in step with aclk.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module csdu_top_tb_top;
   import csdu_pkg::*;
   logic aclk;
   logic aresetn;
   logic [CSDU_ADDR_W-1:0] s_axi_awaddr;
   logic [CSDU_ADDR_W-1:0] s_axi_araddr;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire logic s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [5:0] clk_v;
   wire logic [4:0] osc_v;
   logic [5:0] src_r, prev_v;
   int tk, n_errors, checked;
   int rises[6];
   int since[6];
   // Source half periods in aclk cycles: lp, xosc, pll, ext, ref, diff
   int hp[6] = '{2, 3, 4, 5, 2, 6};

   csdu_top i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .lp_osc_clk(src_r[0]),
      .xosc_clk(src_r[1]), .pll_aux_clk(src_r[2]),
      .ext_pin_clk(src_r[3]), .ref_clk(src_r[4]),
      .diff_in_clk(src_r[5]), .sys_clk(clk_v[0]), .aux_clk(clk_v[1]),
      .cpu_clk(clk_v[2]), .spi_master_clk(clk_v[3]),
      .main_clk(clk_v[4]), .backend_clk(clk_v[5]),
      .xosc_en(osc_v[1]), .xosc_bypass(osc_v[4]),
      .xosc_discap(osc_v[2]), .xosc_dislvl(osc_v[3]),
      .lp_osc_disable(osc_v[0]));

   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // Sources toggle, rising edges are counted, and any pulse shorter than
   // the fastest source half period is taken for a glitch
   always @(posedge aclk)
   begin
      tk <= tk + 1;
      for (int i = 0; i < 6; i++)
      begin
         if (tk % hp[i] == hp[i] - 1)
            src_r[i] <= ~src_r[i];
         if (!aresetn)
            since[i] = 2;
         else if (clk_v[i] !== prev_v[i])
         begin
            `CHK(since[i] >= 2, 1'b1)
            if (clk_v[i])
               rises[i]++;
            since[i] = 0;
         end
         since[i]++;
         prev_v[i] = clk_v[i];
      end
   end

   // Expected output period in aclk cycles; 0 means stopped
   function automatic int exp_per(input logic [7:0] c, m, o, input int k);
      int sp, ap;
      sp = o[5] ? 6 : 4;
      ap = o[6] ? 10 : 8;
      case (k)
         0: return sp;
         1: return ap;
         2: return (c[0] ? ap : sp) << c[3:1];
         3: return c[7:5] == 0 ? 0 : (c[4] ? ap : sp) << (c[7:5] - 1);
         4: return m[7] ? 12 : (m[6] ? ap : sp);
         default: return m[5:3] == 0 ? 0 : (4 << (m[5:3] - 1)) * (m[2:0] + 1);
      endcase
   endfunction

   function automatic logic near(input int n, input int p);
      int e;
      e = (p == 0) ? 0 : 4096 / p;
      return (n >= e - 1) && (n <= e + 1);
   endfunction

   task automatic wr(input logic [7:0] idx, d, input logic [3:0] st,
      input logic [1:0] er);
      logic aw_d, w_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_d && w_d))
      begin
         @(posedge aclk);
         aw_d = aw_d | (s_axi_awready === 1'b1);
         w_d = w_d | (s_axi_wready === 1'b1);
         s_axi_awvalid <= !aw_d;
         s_axi_wvalid <= !w_d;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, er)
      // Let an edge pass so the next call never re-raises bready at once
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] idx, d, input logic [1:0] er);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      `CHK(s_axi_rdata, {24'h0, d})
      `CHK(s_axi_rresp, er)
      @(posedge aclk);
   endtask

   // Settling covers the slowest old period, so the switch has landed
   task automatic cfg(input logic [7:0] c, m, o);
      wr(CSDU_IDX_CLK_CTRL, c, 4'h1, CSDU_RESP_OKAY);
      wr(CSDU_IDX_MAIN_CTRL, m, 4'hf, CSDU_RESP_OKAY);
      wr(CSDU_IDX_OSC_CTRL, o, 4'h1, CSDU_RESP_OKAY);
      rd(CSDU_IDX_CLK_CTRL, c, CSDU_RESP_OKAY);
      rd(CSDU_IDX_MAIN_CTRL, m, CSDU_RESP_OKAY);
      rd(CSDU_IDX_OSC_CTRL, o & 8'h7f, CSDU_RESP_OKAY);
      `CHK(osc_v, o[4:0])
      repeat (2600) @(posedge aclk);
      rises = '{default: 0};
      repeat (4096) @(posedge aclk);
      for (int k = 0; k < 6; k++)
         `CHK(near(rises[k], exp_per(c, m, o, k)), 1'b1)
      // Backend ratio is never zero, so its divider always runs
      rd(CSDU_IDX_STATUS, {1'b1, m[5:3] != 3'h0, c[7:5] != 3'h0, m[7],
         m[6] & !m[7], c[4], o[6], o[5]}, CSDU_RESP_OKAY);
   endtask

   task end_sim;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      aresetn = 1'b0;
      tk = 0;
      src_r = '0;
      prev_v = '0;
      n_errors = 0;
      checked = 0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = '0;
      void'($urandom(30));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK(osc_v, 5'h08)
      rd(CSDU_IDX_CLK_CTRL, 8'h00, CSDU_RESP_OKAY);
      rd(CSDU_IDX_MAIN_CTRL, 8'h00, CSDU_RESP_OKAY);
      rd(CSDU_IDX_OSC_CTRL, 8'h48, CSDU_RESP_OKAY);
      rd(CSDU_IDX_STATUS, 8'h82, CSDU_RESP_OKAY);
      wr(8'h50, 8'h55, 4'h1, CSDU_RESP_SLVERR);
      rd(8'h50, 8'h00, CSDU_RESP_SLVERR);
      wr(CSDU_IDX_STATUS, 8'hff, 4'h1, CSDU_RESP_OKAY);
      wr(CSDU_IDX_CLK_CTRL, 8'hff, 4'h0, CSDU_RESP_OKAY);
      rd(CSDU_IDX_CLK_CTRL, 8'h00, CSDU_RESP_OKAY);
      cfg(8'h00, 8'h00, 8'h00);
      cfg(8'hff, 8'hff, 8'hff);
      cfg(8'h31, 8'h4f, 8'h20);
      repeat (5) cfg(8'($urandom), 8'($urandom), 8'($urandom));
      end_sim;
   end

   initial
   begin
      repeat (80000) @(posedge aclk);
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim;
   end
endmodule // csdu_top_tb_top
